/* File: common/bcc_map.svh */
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// datapath widths
`define BCC_PC_W          32
`define BCC_EXT_W         40
`define BCC_INT_MSB       31
`define BCC_EXP_MSB       39
`define BCC_EXP_LSB       32
`define BCC_CNT_W         2

// program counter arithmetic
`define BCC_PC_RESET      32'h0000_0000
`define BCC_PC_STEP       32'h0000_0001
`define BCC_DELAY_OFFSET  32'h0000_0003

// delay slots behind a delayed branch
`define BCC_DELAY_SLOTS   2'h3
`define BCC_SLOT_LAST     2'h1
`define BCC_SLOT_NONE     2'h0

// extended-precision float: exponent bias flip turns a signed exponent into an ordered key
`define BCC_EXP_FLIP      8'h80

// return-address stack
`define BCC_STACK_DEPTH   8
`define BCC_STACK_AW      3
`define BCC_STACK_PTR_RST 3'h0
`define BCC_STACK_PTR_ONE 3'h1

`endif

/* File: common/bcc_pkg.sv */
package bcc_pkg;

  typedef enum logic [3:0] {
    OP_OTHER,                  // any instruction outside this slice
    OP_BRANCH_IF,              // conditional branch, standard
    OP_BRANCH_IF_DELAYED,      // branch_if_delayed
    OP_JUMP_ALWAYS_STANDARD,   // jump_always_standard
    OP_JUMP_ALWAYS_DELAYED,    // jump_always_delayed
    OP_CALL,                   // unconditional subroutine call
    OP_SUBROUTINE_INVOKE_IF,   // subroutine_invoke_if
    OP_FLOAT_COMPARE_TWO_OP,   // float_compare_two_op
    OP_FLOAT_COMPARE_THREE_OP, // float_compare_three_op
    OP_INT_COMPARE_TWO_OP,     // int_compare_two_op
    OP_INT_COMPARE_THREE_OP    // int_compare_three_op
  } opcode_t;

  typedef struct packed {
    opcode_t     op;           // decoded operation
    logic        condTrue;     // condition code evaluated true
    logic        targetIsReg;  // target operand is a register
    logic [31:0] target;       // register contents or immediate value
    logic [39:0] opA;          // extended_precision_reg / destination / src1
    logic [39:0] opB;          // src / src2
  } instr_t;

  typedef struct packed {
    logic n;                   // negative / less-than
    logic z;                   // zero / equal
    logic v;                   // overflow
    logic c;                   // borrow
  } flags_t;

  typedef struct packed {
    logic        valid;        // push strobe
    logic [31:0] data;         // return address
  } push_t;

endpackage

/* File: rtl/branch_call_compare_exec.sv */
// Operation
// - true conditional branch or call with register target loads register into program_counter.
// - true standard conditional branch or call with immediate: program_counter += immediate.
// - true delayed conditional branch with immediate: target is immediate plus program_counter plus 3.
// - false condition: program_counter advances by 1, stack and flow untouched.
// - calls taken push program_counter plus 1 onto stack_top before transferring.
// - float two-operand compare sets flags on register minus source, writes nothing.
// - integer two-operand compare sets flags on destination minus source, destination unchanged.
// - three-operand compares set flags on src1 minus src2 only, storing nothing.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module branch_call_compare_exec
(
  input  wire logic                core_clk,      // core clock, 250 MHz
  input  wire logic                rst_n,         // synchronous reset, active low
  input  wire logic                instValid,     // one instruction executes this cycle
  input  wire bcc_pkg::instr_t     instr,         // decoded instruction and operands
  output logic [`BCC_PC_W-1:0]     programCounter,// registered program_counter
  output bcc_pkg::flags_t          flags,         // registered status flags
  output logic                     flagsUpdated,  // registered pulse: compare wrote flags
  output logic [`BCC_PC_W-1:0]     stackTop,      // registered stack_top
  output logic [`BCC_STACK_AW-1:0] stackDepth,    // registered push count
  output logic                     delayPending,  // registered: delayed transfer in flight
  output logic                     slotRefused    // comb pulse: transfer in a delay slot ignored
);
  import bcc_pkg::*;

  // ==========================================================
  // arithmetic helpers

  // integer subtract a - b, flags from the 32-bit result
  function automatic flags_t intSubFlags(input logic [`BCC_INT_MSB:0] a,
                                         input logic [`BCC_INT_MSB:0] b);
    logic [`BCC_INT_MSB+1:0] diff;
    flags_t                  f;
    diff = {1'b0, a} - {1'b0, b};
    f.n  = diff[`BCC_INT_MSB];
    f.z  = (diff[`BCC_INT_MSB:0] == '0);
    f.v  = (a[`BCC_INT_MSB] ^ b[`BCC_INT_MSB]) & (a[`BCC_INT_MSB] ^ diff[`BCC_INT_MSB]);
    f.c  = diff[`BCC_INT_MSB+1];
    return f;
  endfunction

  // float subtract a - b reduced to its sign and zero; no result is formed,
  // so only ordering matters and rounding cannot disturb the flags
  function automatic flags_t floatSubFlags(input logic [`BCC_EXT_W-1:0] a,
                                           input logic [`BCC_EXT_W-1:0] b);
    logic                 signA;
    logic                 signB;
    logic [`BCC_EXT_W-1:0] keyA;
    logic [`BCC_EXT_W-1:0] keyB;
    flags_t               f;
    signA = a[`BCC_INT_MSB];
    signB = b[`BCC_INT_MSB];
    keyA  = {a[`BCC_EXP_MSB:`BCC_EXP_LSB] ^ `BCC_EXP_FLIP, a[`BCC_INT_MSB:0]};
    keyB  = {b[`BCC_EXP_MSB:`BCC_EXP_LSB] ^ `BCC_EXP_FLIP, b[`BCC_INT_MSB:0]};
    f.z   = (a == b);
    if (signA != signB)
      f.n = signA;
    else if (signA)
      f.n = (keyA > keyB);
    else
      f.n = (keyA < keyB);
    f.v   = 1'b0;
    f.c   = 1'b0;
    return f;
  endfunction

  // target of a taken conditional transfer
  function automatic logic [`BCC_PC_W-1:0] condTarget(input logic                 isReg,
                                                       input logic [`BCC_PC_W-1:0] value,
                                                       input logic [`BCC_PC_W-1:0] pc,
                                                       input logic [`BCC_PC_W-1:0] offset);
    if (isReg)
      return value;
    return value + pc + offset;
  endfunction

  // ==========================================================
  // state

  logic [`BCC_PC_W-1:0]  pc_q;
  logic [`BCC_PC_W-1:0]  pc_d;
  logic [`BCC_PC_W-1:0]  delayTarget_q;
  logic [`BCC_PC_W-1:0]  delayTarget_d;
  logic [`BCC_CNT_W-1:0] slots_q;
  logic [`BCC_CNT_W-1:0] slots_d;
  flags_t                flags_q;
  flags_t                flags_d;
  logic                  flagsUpd_q;
  logic                  flagsUpd_d;
  push_t                 push;
  logic                  isTransfer;
  logic [`BCC_PC_W-1:0]  pcNext;

  assign pcNext = pc_q + `BCC_PC_STEP;

  // transfers are the only instructions that may not sit in a delay slot
  always_comb
  begin
    case (instr.op)
      OP_BRANCH_IF,
      OP_BRANCH_IF_DELAYED,
      OP_JUMP_ALWAYS_STANDARD,
      OP_JUMP_ALWAYS_DELAYED,
      OP_CALL,
      OP_SUBROUTINE_INVOKE_IF: isTransfer = 1'b1;
      default:                 isTransfer = 1'b0;
    endcase
  end

  // ==========================================================
  // program counter, delay slots and stack push
  // a transfer issued inside delay slots is executed as a plain step:
  // nesting would need a queue of targets that this core does not keep
  always_comb
  begin
    pc_d          = pc_q;
    delayTarget_d = delayTarget_q;
    slots_d       = slots_q;
    push.valid    = 1'b0;
    push.data     = pcNext;
    slotRefused   = 1'b0;
    if (instValid)
    begin
      pc_d = pcNext;
      if (slots_q != `BCC_SLOT_NONE)
      begin
        slots_d     = slots_q - `BCC_SLOT_LAST;
        slotRefused = isTransfer;
        if (slots_q == `BCC_SLOT_LAST)
          pc_d = delayTarget_q;
      end
      else
      begin
        case (instr.op)
          OP_BRANCH_IF:
          begin
            if (instr.condTrue)
              pc_d = condTarget(instr.targetIsReg, instr.target, pc_q, '0);
          end
          OP_BRANCH_IF_DELAYED:
          begin
            if (instr.condTrue)
            begin
              delayTarget_d = condTarget(instr.targetIsReg, instr.target, pc_q, `BCC_DELAY_OFFSET);
              slots_d       = `BCC_DELAY_SLOTS;
            end
          end
          OP_JUMP_ALWAYS_STANDARD:
            pc_d = instr.target;
          OP_JUMP_ALWAYS_DELAYED:
          begin
            delayTarget_d = instr.target;
            slots_d       = `BCC_DELAY_SLOTS;
          end
          OP_CALL:
          begin
            push.valid = 1'b1;
            pc_d       = instr.target;
          end
          OP_SUBROUTINE_INVOKE_IF:
          begin
            if (instr.condTrue)
            begin
              push.valid = 1'b1;
              pc_d       = condTarget(instr.targetIsReg, instr.target, pc_q, '0);
            end
          end
          default:
            pc_d = pcNext;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pc_q          <= `BCC_PC_RESET;
      delayTarget_q <= `BCC_PC_RESET;
      slots_q       <= `BCC_SLOT_NONE;
    end
    else
    begin
      pc_q          <= pc_d;
      delayTarget_q <= delayTarget_d;
      slots_q       <= slots_d;
    end
  end

  // ==========================================================
  // compares: flags only, no register write port exists here at all
  always_comb
  begin
    flags_d    = flags_q;
    flagsUpd_d = 1'b0;
    if (instValid)
    begin
      case (instr.op)
        OP_FLOAT_COMPARE_TWO_OP,
        OP_FLOAT_COMPARE_THREE_OP:
        begin
          flags_d    = floatSubFlags(instr.opA, instr.opB);
          flagsUpd_d = 1'b1;
        end
        OP_INT_COMPARE_TWO_OP,
        OP_INT_COMPARE_THREE_OP:
        begin
          flags_d    = intSubFlags(instr.opA[`BCC_INT_MSB:0], instr.opB[`BCC_INT_MSB:0]);
          flagsUpd_d = 1'b1;
        end
        default:
          flagsUpd_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      flags_q    <= '0;
      flagsUpd_q <= 1'b0;
    end
    else
    begin
      flags_q    <= flags_d;
      flagsUpd_q <= flagsUpd_d;
    end
  end

  // ==========================================================
  // return-address stack
  return_stack u_stack
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (push),
    .stackTop (stackTop),
    .depth    (stackDepth)
  );

  assign programCounter = pc_q;
  assign flags          = flags_q;
  assign flagsUpdated   = flagsUpd_q;
  assign delayPending   = (slots_q != `BCC_SLOT_NONE);

endmodule

`default_nettype wire

/* File: rtl/return_stack.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module return_stack
(
  input  wire logic                  core_clk, // core clock
  input  wire logic                  rst_n,    // synchronous reset, active low
  input  wire bcc_pkg::push_t        push,     // push request with data
  output logic [`BCC_PC_W-1:0]       stackTop, // registered top of stack
  output logic [`BCC_STACK_AW-1:0]   depth     // entries pushed, wraps when full
);
  import bcc_pkg::*;

  logic [`BCC_PC_W-1:0]     mem_q [`BCC_STACK_DEPTH];
  logic [`BCC_STACK_AW-1:0] ptr_q;
  logic [`BCC_STACK_AW-1:0] ptr_d;
  logic [`BCC_PC_W-1:0]     top_q;
  logic [`BCC_PC_W-1:0]     top_d;

  // ==========================================================
  // pointer and top next state
  // overflow wraps and overwrites the oldest entry; no trap here
  always_comb
  begin
    ptr_d = ptr_q;
    top_d = top_q;
    if (push.valid)
    begin
      ptr_d = ptr_q + `BCC_STACK_PTR_ONE;
      top_d = push.data;
    end
  end

  // storage has no reset, only the pointer and top do
  always_ff @(posedge core_clk)
  begin
    if (push.valid)
      mem_q[ptr_q] <= push.data;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ptr_q <= `BCC_STACK_PTR_RST;
      top_q <= `BCC_PC_RESET;
    end
    else
    begin
      ptr_q <= ptr_d;
      top_q <= top_d;
    end
  end

  assign stackTop = top_q;
  assign depth    = ptr_q;

endmodule

`default_nettype wire

/* File: test/branch_call_compare_exec_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
// ========================================
// checker: program flow and flag updates seen at the ports
module branch_call_compare_exec_chk
(
  input wire logic                     core_clk,       // core clock
  input wire logic                     rst_n,          // synchronous reset, active low
  input wire logic                     instValid,      // instruction executes
  input wire bcc_pkg::instr_t          instr,          // decoded instruction
  input wire logic [`BCC_PC_W-1:0]     programCounter, // program counter
  input wire bcc_pkg::flags_t          flags,          // status flags
  input wire logic                     flagsUpdated,   // compare pulse
  input wire logic [`BCC_PC_W-1:0]     stackTop,       // return address
  input wire logic [`BCC_STACK_AW-1:0] stackDepth,     // push count
  input wire logic                     delayPending,   // delay slots open
  input wire logic                     slotRefused     // transfer ignored in a slot
);
  import bcc_pkg::*;
  // transfers issued inside delay slots are refused, so only free issues count
  wire logic taken = instValid && !delayPending;
  wire logic condOp = instr.op == OP_BRANCH_IF || instr.op == OP_SUBROUTINE_INVOKE_IF;
  wire logic xferOp = instr.op inside {[OP_BRANCH_IF:OP_SUBROUTINE_INVOKE_IF]};
  wire logic cmpOp = instr.op inside {[OP_FLOAT_COMPARE_TWO_OP:OP_INT_COMPARE_THREE_OP]};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // delayed transfers: issue, then three counted instructions
  sequence delayIssue;
    taken && (instr.op == OP_JUMP_ALWAYS_DELAYED || (instr.op == OP_BRANCH_IF_DELAYED && instr.condTrue));
  endsequence
  sequence relDelayIssue;
    taken && instr.op == OP_BRANCH_IF_DELAYED && instr.condTrue && !instr.targetIsReg;
  endsequence
  sequence threeSlots;
    instValid [*3];
  endsequence

  chk_false_step: assert property (taken && condOp && !instr.condTrue |=>
    programCounter == $past(programCounter) + 32'h1 && $stable(stackDepth)) else $error("false step wrong");
  chk_reg_target: assert property (taken && condOp && instr.condTrue && instr.targetIsReg |=>
    programCounter == $past(instr.target)) else $error("register target wrong");
  chk_imm_target: assert property (taken && condOp && instr.condTrue && !instr.targetIsReg |=>
    programCounter == $past(instr.target) + $past(programCounter)) else $error("relative target wrong");
  chk_call_push: assert property (taken && (instr.op == OP_CALL || (instr.op == OP_SUBROUTINE_INVOKE_IF &&
    instr.condTrue)) |=> stackTop == $past(programCounter) + 32'h1 && stackDepth == $past(stackDepth) + 3'h1)
    else $error("return address push wrong");
  chk_jump_abs: assert property (taken && (instr.op == OP_JUMP_ALWAYS_STANDARD || instr.op == OP_CALL) |=>
    programCounter == $past(instr.target)) else $error("absolute target wrong");
  chk_cmp_pulse: assert property (instValid && cmpOp |=> flagsUpdated) else $error("no flag pulse");
  chk_flags_hold: assert property (!(instValid && cmpOp) |=> $stable(flags) && !flagsUpdated)
    else $error("flags moved without compare");
  chk_delay_enter: assert property (delayIssue |=> delayPending &&
    programCounter == $past(programCounter) + 32'h1) else $error("delayed issue wrong");
  chk_delay_land: assert property (relDelayIssue ##1 threeSlots |=> !delayPending &&
    programCounter == $past(instr.target, 4) + $past(programCounter, 4) + 32'h3) else $error("delayed landing wrong");
  chk_slot_refuse: assert property (instValid && delayPending && xferOp |-> slotRefused ##1 $stable(stackDepth))
    else $error("slot transfer not refused");
endmodule

bind branch_call_compare_exec branch_call_compare_exec_chk chk (.core_clk(core_clk), .rst_n(rst_n),
  .instValid(instValid), .instr(instr), .programCounter(programCounter), .flags(flags),
  .flagsUpdated(flagsUpdated), .stackTop(stackTop), .stackDepth(stackDepth),
  .delayPending(delayPending), .slotRefused(slotRefused));
`default_nettype wire

/* File: test/branch_call_compare_exec_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
// ========================================
// self-checking bench; expected pc is tracked here, never read back
module branch_call_compare_exec_tb;
  import bcc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instValid = 1'b0;
  instr_t      instr = '0;
  logic [31:0] pcOut, stOut;
  flags_t      flagsOut;
  logic        fuOut, dpOut, srOut, srSeen;
  logic [2:0]  sdOut;
  logic [31:0] ePc = 32'h0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;

  branch_call_compare_exec uut (.core_clk(core_clk), .rst_n(rst_n), .instValid(instValid), .instr(instr),
    .programCounter(pcOut), .flags(flagsOut), .flagsUpdated(fuOut), .stackTop(stOut), .stackDepth(sdOut),
    .delayPending(dpOut), .slotRefused(srOut));

  // ========================================
  // clock and hang guard
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ========================================
  // shared tasks
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [39:0] s, input logic [39:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t saw %h expected %h", $time, s, e);
    end
  endtask
  // valid stays up so back-to-back issues never toggle it within one step
  task issue(input opcode_t o, input logic c, r, input logic [31:0] t, input logic [39:0] a, b);
    instValid = 1'b1;
    instr = '{o, c, r, t, a, b};
    #1 srSeen = srOut;
    @(posedge core_clk);
    #1;
  endtask
  task idle;
    instValid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task cmp(input opcode_t o, input logic [39:0] a, b, input logic [3:0] f);
    issue(o, 1'b1, 1'b0, 32'h0, a, b);
    ePc += 32'h1;
    check(pcOut, ePc);
    check(flagsOut, f);
    check(fuOut, 1'b1);
  endtask

  // ========================================
  // scenarios
  task tst_transfer;
    issue(OP_BRANCH_IF, 1'b0, 1'b0, 32'h40, '0, '0);
    check(pcOut, ++ePc);
    issue(OP_BRANCH_IF, 1'b1, 1'b0, 32'h10, '0, '0);
    check(pcOut, (ePc += 32'h10));
    issue(OP_BRANCH_IF, 1'b1, 1'b1, 32'h200, '0, '0);
    check(pcOut, (ePc = 32'h200));
    issue(OP_SUBROUTINE_INVOKE_IF, 1'b0, 1'b0, 32'h5, '0, '0);
    check(sdOut, 3'h0);
    check(pcOut, ++ePc);
    issue(OP_SUBROUTINE_INVOKE_IF, 1'b1, 1'b0, 32'h20, '0, '0);
    check(stOut, ePc + 32'h1);
    check(pcOut, (ePc += 32'h20));
    issue(OP_CALL, 1'b1, 1'b0, 32'h300, '0, '0);
    check(srSeen, 1'b0);
    check(stOut, ePc + 32'h1);
    check(sdOut, 3'h2);
    check(pcOut, (ePc = 32'h300));
    issue(OP_JUMP_ALWAYS_STANDARD, 1'b1, 1'b0, 32'h80, '0, '0);
    check(pcOut, (ePc = 32'h80));
    idle();
  endtask
  // a refused call and a compare sit inside the slots of a relative delayed branch
  task tst_delay;
    logic [31:0] base;
    base = ePc;
    issue(OP_BRANCH_IF_DELAYED, 1'b1, 1'b0, 32'h10, '0, '0);
    check(pcOut, ++ePc);
    check(dpOut, 1'b1);
    issue(OP_CALL, 1'b1, 1'b0, 32'h900, '0, '0);
    check(srSeen, 1'b1);
    check(sdOut, 3'h2);
    check(pcOut, ++ePc);
    cmp(OP_INT_COMPARE_TWO_OP, 40'h5, 40'h7, 4'b1001);
    issue(OP_OTHER, 1'b0, 1'b0, 32'h0, '0, '0);
    check(pcOut, (ePc = base + 32'h13));
    check(dpOut, 1'b0);
    // idle cycles must not use up a slot
    issue(OP_JUMP_ALWAYS_DELAYED, 1'b1, 1'b0, 32'h500, '0, '0);
    idle();
    repeat (3) issue(OP_OTHER, 1'b0, 1'b0, 32'h0, '0, '0);
    check(pcOut, (ePc = 32'h500));
    // a false delayed branch opens no slots
    issue(OP_BRANCH_IF_DELAYED, 1'b0, 1'b0, 32'h40, '0, '0);
    check(pcOut, ++ePc);
    check(dpOut, 1'b0);
    // delayed branch to a register lands on the register value itself
    issue(OP_BRANCH_IF_DELAYED, 1'b1, 1'b1, 32'h600, '0, '0);
    check(pcOut, ++ePc);
    check(dpOut, 1'b1);
    repeat (3) issue(OP_OTHER, 1'b0, 1'b0, 32'h0, '0, '0);
    check(pcOut, (ePc = 32'h600));
    check(dpOut, 1'b0);
    idle();
  endtask
  task tst_compare;
    cmp(OP_INT_COMPARE_TWO_OP, 40'h9, 40'h9, 4'b0100);
    idle();
    check(fuOut, 1'b0);
    cmp(OP_INT_COMPARE_THREE_OP, 40'h3, 40'h8, 4'b1001);
    cmp(OP_FLOAT_COMPARE_TWO_OP, 40'h01_0000_0001, 40'h01_0000_0001, 4'b0100);
    cmp(OP_FLOAT_COMPARE_THREE_OP, 40'h01_0000_0001, 40'h02_0000_0001, 4'b1000);
    idle();
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check(pcOut, 32'h0);
    tst_transfer();
    tst_delay();
    tst_compare();
    conclude();
  end
endmodule
`default_nettype wire
